// ### include/engine_ctrl_map.vh
// Register offsets, field positions, reset values and counts for the engine control block.
`ifndef ENGINE_CTRL_MAP_VH
`define ENGINE_CTRL_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFF_COMMON_CONTROL 12'h000
`define OFF_COMMON_STATUS 12'h004
`define OFF_IRQ_STATUS 12'h020
`define OFF_IRQ_MASK 12'h024
`define OFF_ERROR_INFO 12'h028

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_RUN_STOP_BIT 0
`define CTL_SOFT_RESET_BIT 2
`define STS_HALTED_BIT 0
`define STS_IDLE_BIT 1
`define IRQ_HALTED_EV 0
`define IRQ_IDLE_EV 1
`define IRQ_ERROR_EV 2
`define IRQ_RESET_DONE_EV 3
`define IRQ_WIDTH 4

// ****************************************************************
// Reset values
// ****************************************************************
`define CONTROL_RESET 32'h0000_0000
`define STATUS_RESET 32'h0000_0001
`define IRQ_MASK_RESET 4'h0

// ****************************************************************
// Timing: longest drain wait during a soft reset
// ****************************************************************
`define DRAIN_TIMEOUT_NS 51200
`define CLK_PERIOD_NS 50
`define DRAIN_TIMEOUT_CYCLES (`DRAIN_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// ### core/pulse_sync.v
// Two flip-flop level synchroniser for a bus of inputs from another domain.
`timescale 1ns/1ps
`default_nettype none

module pulse_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second, to let metastability settle.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule
`default_nettype wire

// ### core/drain_timer.v
// Watchdog counter that bounds how long a drain may wait for the datapath.
`timescale 1ns/1ps
`default_nettype none

module drain_timer #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire rst_n,
   input wire run,
   input wire [WIDTH-1:0] limit,
   output reg expired
);

   reg [WIDTH-1:0] count_reg;

   // Counts while run is high; clears as soon as run drops.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= {WIDTH{1'b0}};
         expired <= 1'b0;
      end else if (!run) begin
         count_reg <= {WIDTH{1'b0}};
         expired <= 1'b0;
      end else if (count_reg >= limit) begin
         expired <= 1'b1;
      end else begin
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

endmodule
`default_nettype wire

// ### core/engine_run_reset_ctrl.v
// Run/stop, graceful soft reset, halted/idle status and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "engine_ctrl_map.vh"

module engine_run_reset_ctrl #(
   parameter NUM_CHANNELS = 16,
   parameter DRAIN_CYCLES = `DRAIN_TIMEOUT_CYCLES
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [NUM_CHANNELS-1:0] chan_at_tail,
   input wire desc_queue_empty,
   input wire cmd_outstanding,
   input wire update_queue_busy,
   input wire [NUM_CHANNELS-1:0] tail_ptr_write,
   input wire error_event,
   output reg engine_run,
   output reg engine_flush,
   output reg core_reset_n,
   output reg irq
);

   // ****************************************************************
   // State encoding
   // ****************************************************************
   localparam [1:0] ST_HALTED = 2'd0;
   localparam [1:0] ST_RUNNING = 2'd1;
   localparam [1:0] ST_STOPPING = 2'd2;
   localparam [1:0] ST_RESETTING = 2'd3;
   // The parameter is unsized, so it is given a width before it is cut.
   localparam [31:0] DRAIN_CYCLES_W = DRAIN_CYCLES;
   localparam [15:0] DRAIN_LIMIT = DRAIN_CYCLES_W[15:0];

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg run_stop_reg;
   reg soft_reset_reg;
   reg halted_reg;
   reg idle_reg;
   reg error_latched_reg;
   reg [`IRQ_WIDTH-1:0] irq_status_reg;
   reg [`IRQ_WIDTH-1:0] irq_mask_reg;
   reg [`IRQ_WIDTH-1:0] irq_event;
   reg [31:0] rdata_next;
   reg slverr_next;
   reg reset_pulse_reg;

   wire [NUM_CHANNELS-1:0] tail_sync;
   wire [2:0] misc_sync;
   wire err_s;
   wire busy_s;
   wire upd_s;
   wire queue_empty_s;
   wire drain_expired;
   wire drained;
   wire all_at_tail;
   wire bus_access;
   wire bus_write;
   wire bus_read;
   wire ctl_write;
   wire status_read;
   wire irq_read;
   wire tail_write_any;
   wire [NUM_CHANNELS-1:0] tail_write_s;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************

   // Datapath status comes from pins, so each bit passes two flops.
   pulse_sync #(.WIDTH(NUM_CHANNELS)) u_tail_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(chan_at_tail),
      .sync_out(tail_sync)
   );

   pulse_sync #(.WIDTH(4)) u_misc_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({error_event, cmd_outstanding, update_queue_busy,
         desc_queue_empty}),
      .sync_out({err_s, misc_sync})
   );

   pulse_sync #(.WIDTH(NUM_CHANNELS)) u_tailwr_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(tail_ptr_write),
      .sync_out(tail_write_s)
   );

   assign busy_s = misc_sync[2];
   assign upd_s = misc_sync[1];
   assign queue_empty_s = misc_sync[0];

   // Write-backs in the update queue count as outstanding work.
   assign drained = !busy_s && !upd_s;
   assign all_at_tail = &tail_sync;
   assign tail_write_any = |tail_write_s;

   // ****************************************************************
   // Drain watchdog
   // ****************************************************************

   // A stuck datapath must not hang a soft reset forever, so the wait
   // is bounded; on expiry the flush ends, the core reset pulses and in-flight read data
   // is simply dropped.
   drain_timer #(.WIDTH(16)) u_drain_timer (
      .clk(pclk),
      .rst_n(presetn),
      .run(state_reg == ST_RESETTING),
      .limit(DRAIN_LIMIT),
      .expired(drain_expired)
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign bus_access = psel && penable;
   assign bus_write = bus_access && pwrite;
   assign bus_read = bus_access && !pwrite;
   assign ctl_write = bus_write && (paddr == `OFF_COMMON_CONTROL);
   assign status_read = bus_read && (paddr == `OFF_COMMON_STATUS);
   assign irq_read = bus_read && (paddr == `OFF_IRQ_STATUS);

   // ****************************************************************
   // Engine state machine
   // ****************************************************************

   // Next-state logic for run, stop and soft reset sequencing.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_HALTED: begin
            if (run_stop_reg && !error_latched_reg) begin
               state_next = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (!run_stop_reg) begin
               state_next = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            // Read data in flight is waited for here; no watchdog cuts it short.
            if (drained) begin
               state_next = ST_HALTED;
            end
         end
         ST_RESETTING: begin
            if (drained || drain_expired) begin
               state_next = ST_HALTED;
            end
         end
         default: begin
            state_next = ST_HALTED;
         end
      endcase
      if (soft_reset_reg && state_reg != ST_RESETTING) begin
         state_next = ST_RESETTING;
      end
      // The cycle after the reset pulse lands in halted, so a stale run
      // or soft reset bit cannot start a second pass.
      if (reset_pulse_reg) begin
         state_next = ST_HALTED;
      end
   end

   // State register, engine outputs and the reset pulse to the core.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_HALTED;
         engine_run <= 1'b0;
         engine_flush <= 1'b0;
         core_reset_n <= 1'b1;
         reset_pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         engine_run <= (state_next == ST_RUNNING);
         engine_flush <= (state_next == ST_RESETTING);
         // Pulse low for one cycle to reset both directions.
         reset_pulse_reg <= (state_reg == ST_RESETTING) &&
            (state_next == ST_HALTED);
         core_reset_n <= !((state_reg == ST_RESETTING) &&
            (state_next == ST_HALTED));
      end
   end

   // ****************************************************************
   // Control and status registers
   // ****************************************************************

   // Control bits; the soft reset end restores every reset value.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_stop_reg <= 1'b0;
         soft_reset_reg <= 1'b0;
         error_latched_reg <= 1'b0;
         halted_reg <= 1'b1;
         idle_reg <= 1'b0;
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else if (reset_pulse_reg) begin
         // Everything returns to reset; software reprograms.
         run_stop_reg <= 1'b0;
         soft_reset_reg <= 1'b0;
         error_latched_reg <= 1'b0;
         halted_reg <= 1'b1;
         idle_reg <= 1'b0;
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else begin
         if (err_s) begin
            // Error wins over a write of the run bit.
            run_stop_reg <= 1'b0;
            error_latched_reg <= 1'b1;
         end else if (ctl_write) begin
            // Software may drop run at any moment.
            run_stop_reg <= pwdata[`CTL_RUN_STOP_BIT] &&
               !error_latched_reg;
         end else if (tail_write_any && idle_reg && !error_latched_reg) begin
            run_stop_reg <= 1'b1;
         end
         if (ctl_write && pwdata[`CTL_SOFT_RESET_BIT]) begin
            soft_reset_reg <= 1'b1;
         end
         // Halted lags run clearing until the drain is done; a soft reset sets it at once.
         halted_reg <= (state_next == ST_HALTED) ||
            (state_next == ST_RESETTING);
         idle_reg <= (state_next == ST_RUNNING) && all_at_tail &&
            queue_empty_s && drained && !tail_write_any;
         if (bus_write && paddr == `OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
         end
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************

   // Event sources: halted rising after a stop, idle rising, error, reset done.
   always @* begin
      irq_event = {`IRQ_WIDTH{1'b0}};
      irq_event[`IRQ_HALTED_EV] = !halted_reg &&
         (state_next == ST_HALTED);
      irq_event[`IRQ_IDLE_EV] = !idle_reg && (state_next == ST_RUNNING) &&
         all_at_tail && queue_empty_s && drained && !tail_write_any;
      irq_event[`IRQ_ERROR_EV] = err_s && !error_latched_reg;
      irq_event[`IRQ_RESET_DONE_EV] = reset_pulse_reg;
   end

   // Sticky status; a read clears it, but a same-cycle event wins.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= {`IRQ_WIDTH{1'b0}};
         irq <= 1'b0;
      end else if (reset_pulse_reg) begin
         // Old events go with the soft reset; only its done bit stays.
         irq_status_reg <= irq_event;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= (irq_read ? {`IRQ_WIDTH{1'b0}} :
            irq_status_reg) | irq_event;
         irq <= |(((irq_read ? {`IRQ_WIDTH{1'b0}} : irq_status_reg) |
            irq_event) & irq_mask_reg);
      end
   end

   // ****************************************************************
   // APB read path
   // ****************************************************************

   // Read mux; reserved bits read as zero.
   always @* begin
      rdata_next = 32'h0000_0000;
      slverr_next = 1'b0;
      case (paddr)
         `OFF_COMMON_CONTROL: begin
            rdata_next[`CTL_RUN_STOP_BIT] = run_stop_reg;
            rdata_next[`CTL_SOFT_RESET_BIT] = soft_reset_reg;
         end
         `OFF_COMMON_STATUS: begin
            rdata_next[`STS_HALTED_BIT] = halted_reg;
            rdata_next[`STS_IDLE_BIT] = idle_reg;
         end
         `OFF_IRQ_STATUS: begin
            rdata_next[`IRQ_WIDTH-1:0] = irq_status_reg;
         end
         `OFF_IRQ_MASK: begin
            rdata_next[`IRQ_WIDTH-1:0] = irq_mask_reg;
         end
         `OFF_ERROR_INFO: begin
            rdata_next[0] = error_latched_reg;
         end
         default: begin
            slverr_next = 1'b1;
         end
      endcase
   end

   // Zero-wait answer: pready and data register in the setup cycle so
   // they stand during the access phase.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && slverr_next;
         // An unmapped write also loads the zero data, so an error answer
         // never carries stale bits from an earlier read.
         if (psel && !penable && (!pwrite || slverr_next)) begin
            prdata <= rdata_next;
         end
      end
   end

endmodule
`default_nettype wire

// ### verif/engine_ctrl_properties.sv
// Port-level assertions for the engine run and soft reset control block.
`timescale 1ns/1ps
`default_nettype none
module engine_ctrl_properties #(
   parameter DRAIN_CYCLES = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire error_event,
   input wire engine_run,
   input wire engine_flush,
   input wire core_reset_n
);
   // ****************************************************************
   // Access strobes and bounds
   // ****************************************************************
   // The margin covers the input synchronisers and the final pulse.
   localparam int DMAX = DRAIN_CYCLES + 8;
   // Completed accesses to the two common registers.
   wire ap = psel && penable && pready;
   wire wr0 = ap && pwrite && (paddr == 12'h000);
   wire rd0 = ap && !pwrite && (paddr == 12'h000);
   wire rd4 = ap && !pwrite && (paddr == 12'h004);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_err_data: assert property (pslverr |-> pready && prdata == 0)
      else $error("slave error without clean answer");
   chk_flush_start: assert property (
      wr0 && pwdata[2] |-> ##[1:4] engine_flush)
      else $error("soft reset write did not start flush");
   chk_flush_bound: assert property (
      $rose(engine_flush) |-> ##[1:DMAX] !core_reset_n)
      else $error("soft reset never completed");
   chk_pulse_width: assert property (
      $fell(core_reset_n) |=> core_reset_n)
      else $error("core reset pulse longer than one cycle");
   chk_clear_after: assert property (
      !core_reset_n |-> ##[1:3] (!engine_run && !engine_flush))
      else $error("state not cleared after soft reset");
   chk_bit_reads: assert property (
      rd0 && engine_flush && $past(engine_flush) |-> prdata[2])
      else $error("soft reset bit low during reset");
   chk_stop_run: assert property (
      wr0 && !pwdata[0] |-> ##[1:2] !engine_run)
      else $error("run stayed on after stop write");
   chk_err_stop: assert property (
      error_event |-> ##[1:6] !engine_run)
      else $error("run stayed on after error");
   chk_ctl_rsvd: assert property (
      rd0 |-> prdata[31:3] == 0 && !prdata[1])
      else $error("control reserved bits not zero");
   chk_sts_rsvd: assert property (
      rd4 |-> prdata[31:2] == 0)
      else $error("status reserved bits not zero");
endmodule
bind engine_run_reset_ctrl engine_ctrl_properties #(
   .DRAIN_CYCLES(DRAIN_CYCLES)
) engine_ctrl_properties_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .error_event(error_event), .engine_run(engine_run),
   .engine_flush(engine_flush), .core_reset_n(core_reset_n));
`default_nettype wire

// ### verif/datapath_model.sv
// Behavioural datapath that drains a given amount of work.
`timescale 1ns/1ps
`default_nettype none
module datapath_model #(
   parameter NCH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic engine_run,
   input wire logic core_reset_n,
   input wire logic [NCH-1:0] tail_ptr_write,
   input wire logic [7:0] work_len,
   output logic [NCH-1:0] chan_at_tail,
   output logic desc_queue_empty,
   output logic cmd_outstanding,
   output logic update_queue_busy
);
   logic [7:0] cnt_reg;
   logic run_d_reg;
   // Work loads on a start or a tail write and drains one unit a cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
         run_d_reg <= 1'b0;
      end else begin
         run_d_reg <= engine_run;
         if (!core_reset_n) begin
            cnt_reg <= 8'h00;
         end else if ((engine_run && !run_d_reg) || |tail_ptr_write) begin
            cnt_reg <= work_len;
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
   // Write-backs outlast the commands, so a halt must wait for both.
   assign cmd_outstanding = cnt_reg > 8'h03;
   assign update_queue_busy = cnt_reg != 8'h00;
   assign desc_queue_empty = cnt_reg == 8'h00;
   assign chan_at_tail = {NCH{cnt_reg == 8'h00}};
endmodule
`default_nettype wire

// ### verif/engine_run_reset_ctrl_test.sv
// Self-checking bench for the engine run and soft reset control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares = compares + 1; \
   if ((g) !== (e)) begin failures = failures + 1; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module engine_run_reset_ctrl_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic pready, pslverr, rerr, error_event = 0;
   logic [3:0] tail_ptr_write = 0, chan_at_tail;
   logic [7:0] work_len = 8'h14;
   logic desc_queue_empty, cmd_outstanding, update_queue_busy;
   logic engine_run, engine_flush, core_reset_n, irq;
   integer failures = 0, compares = 0, cyc = 0, n;
   engine_run_reset_ctrl #(.NUM_CHANNELS(4), .DRAIN_CYCLES(16))
   engine_run_reset_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_at_tail(chan_at_tail),
      .desc_queue_empty(desc_queue_empty),
      .cmd_outstanding(cmd_outstanding),
      .update_queue_busy(update_queue_busy),
      .tail_ptr_write(tail_ptr_write), .error_event(error_event),
      .engine_run(engine_run), .engine_flush(engine_flush),
      .core_reset_n(core_reset_n), .irq(irq));
   datapath_model #(.NCH(4)) datapath_model_inst (.pclk(pclk),
      .presetn(presetn), .engine_run(engine_run),
      .core_reset_n(core_reset_n), .tail_ptr_write(tail_ptr_write),
      .work_len(work_len), .chan_at_tail(chan_at_tail),
      .desc_queue_empty(desc_queue_empty),
      .cmd_outstanding(cmd_outstanding),
      .update_queue_busy(update_queue_busy));
   // ****************************************************************
   // Clock, timeout and bus tasks
   // ****************************************************************
   // The clock toggles every half period of 25 ns.
   always #25 pclk = ~pclk;
   // Cuts a hang short well beyond the few hundred cycles needed.
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One APB transfer; an idle edge follows so the next can start cleanly.
   task automatic apb(input [11:0] a, input w, input [31:0] d);
      psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wr(input [11:0] a, input [31:0] d);
      apb(a, 1, d);
   endtask
   task automatic rd(input [11:0] a);
      apb(a, 0, 32'h0000_0000);
   endtask
   // Polls status rather than assuming how soon a state is reached.
   task automatic wait_sts(input integer b, input v);
      n = 0;
      rd(12'h004);
      while (rdat[b] !== v && n < 60) begin
         n = n + 1;
         rd(12'h004);
      end
   endtask
   task automatic tail_pulse();
      tail_ptr_write <= 4'h4;
      @(posedge pclk);
      tail_ptr_write <= 4'h0;
      @(posedge pclk);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rd(12'h000); `CHK("ctrl", 32'h0000_0000, rdat)
      wr(12'h004, 32'h0000_0000);
      rd(12'h004); `CHK("status", 32'h0000_0001, rdat)
      rd(12'h100); `CHK("unmapped", 1'b1, rerr)
      $display("done reset");
   endtask
   task automatic t_run();
      wr(12'h000, 32'hFFFF_FFF9);
      rd(12'h000); `CHK("ctrl rsvd", 32'h0000_0001, rdat)
      // Let the first load drain so that the idle seen below is real.
      repeat (30) @(posedge pclk);
      wait_sts(1, 1'b1);
      `CHK("running idle", 32'h0000_0002, rdat)
      tail_pulse();
      repeat (4) @(posedge pclk);
      rd(12'h004); `CHK("restart", 1'b0, rdat[1])
      wr(12'h000, 32'h0000_0000);
      rd(12'h004); `CHK("halt lag", 1'b0, rdat[0])
      wait_sts(0, 1'b1);
      `CHK("halted", 32'h0000_0001, rdat)
      `CHK("wb done", 1'b0, update_queue_busy)
      $display("done run");
   endtask
   task automatic t_irq();
      wr(12'h024, 32'h0000_0000);
      rd(12'h020);
      wr(12'h000, 32'h0000_0001);
      wait_sts(0, 1'b0);
      wr(12'h000, 32'h0000_0000);
      wait_sts(0, 1'b1);
      `CHK("irq masked", 1'b0, irq)
      wr(12'h024, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      `CHK("irq on", 1'b1, irq)
      rd(12'h020); `CHK("irq halt", 1'b1, rdat[0])
      repeat (2) @(posedge pclk);
      `CHK("irq clear", 1'b0, irq)
      $display("done irq");
   endtask
   task automatic t_error();
      wr(12'h000, 32'h0000_0001);
      wait_sts(0, 1'b0);
      error_event <= 1;
      repeat (2) @(posedge pclk);
      error_event <= 0;
      repeat (8) @(posedge pclk);
      rd(12'h000); `CHK("err run", 1'b0, rdat[0])
      rd(12'h028); `CHK("err latch", 1'b1, rdat[0])
      wr(12'h000, 32'h0000_0001);
      rd(12'h000); `CHK("err lock", 1'b0, rdat[0])
      $display("done error");
   endtask
   task automatic t_soft();
      wr(12'h024, 32'h0000_000F);
      work_len <= 8'h1E;
      tail_pulse();
      wr(12'h000, 32'h0000_0004);
      rd(12'h000); `CHK("rst bit", 1'b1, rdat[2])
      `CHK("graceful", 1'b1, core_reset_n)
      n = 0;
      while (core_reset_n !== 1'b0 && n < 80) begin
         n = n + 1;
         @(posedge pclk);
      end
      `CHK("pulse", 1'b0, core_reset_n)
      repeat (3) @(posedge pclk);
      rd(12'h000); `CHK("ctrl clr", 32'h0000_0000, rdat)
      rd(12'h004); `CHK("sts clr", 32'h0000_0001, rdat)
      rd(12'h024); `CHK("mask clr", 32'h0000_0000, rdat)
      rd(12'h028); `CHK("err clr", 1'b0, rdat[0])
      rd(12'h020); `CHK("irq clr", 32'h0000_0008, rdat)
      wr(12'h000, 32'h0000_0001);
      wait_sts(0, 1'b0); `CHK("rerun", 1'b0, rdat[0])
      $display("done soft");
   endtask
   // Holds reset for ten cycles, then runs the scenarios in turn.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset();
      t_run();
      t_irq();
      t_error();
      t_soft();
      stop_test();
   end
endmodule
`default_nettype wire
